// >>> rtl/ldr_pkg.sv
// Constants for the loop diagnostic result status block.
// Assumes a 32-bit SPI frame, MSB first, with the command in the upper half.
package ldr_pkg;

    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // SPI framing
    // ----------------------------------------------------------------
    localparam int FRAME_BITS = 32;
    localparam logic [7:0] RESULT_ID = 8'h37;
    localparam logic [15:0] RESULT_READ_CODE = 16'h3700;
    localparam int CMD_HI = 31;
    localparam int CMD_LO = 16;
    localparam int ID_HI = 31;
    localparam int ID_LO = 24;
    localparam logic [3:0] REPLY_PAD = 4'h0;

    // ----------------------------------------------------------------
    // Result word layout
    // ----------------------------------------------------------------
    localparam int RESULT_BITS = 20;
    localparam logic [19:0] RESULT_RESET = 20'h00000;
    localparam int DIAG_LEVEL_BIT = 19;
    localparam int TEST_IN_PROGRESS_BIT = 18;
    localparam int UNUSED_BIT = 17;
    localparam int PRIOR_FAULT_BIT = 16;
    localparam int TRANSISTOR_ON_BIT = 15;
    localparam int HIGHSIDE_PASS_BIT = 14;
    localparam int RES_ABOVE_BIT = 13;
    localparam int RES_BELOW_BIT = 12;
    localparam int CODE_HI = 11;
    localparam int CODE_LO = 8;
    localparam int INTER_SHORT_BIT = 7;
    localparam int GROUND_SHORT_BIT = 6;
    localparam int BATTERY_SHORT_BIT = 5;
    localparam int LEAK_PIN_BIT = 4;
    localparam int LEAK_CHAN_HI = 3;
    localparam int LEAK_CHAN_LO = 0;

    // ----------------------------------------------------------------
    // Codes
    // ----------------------------------------------------------------
    localparam logic [3:0] CHAN_LAST = 4'h7;
    localparam logic [3:0] CHAN_NONE = 4'hF;
    localparam logic [3:0] AUTO_NONE = 4'h0;
    localparam logic [3:0] AUTO_CURRENT_MON = 4'h1;
    localparam logic [3:0] AUTO_LEAKAGE = 4'h2;
    localparam logic [3:0] AUTO_INTER_SHORT = 4'h3;
    localparam logic [3:0] AUTO_RES_RANGE = 4'h5;
    localparam logic [3:0] AUTO_RES_MEAS = 4'h6;
    localparam logic [3:0] AUTO_TRANSISTOR = 4'h7;
    localparam logic LEAK_PIN_RETURN = 1'b0;
    localparam logic LEAK_PIN_FEED = 1'b1;

    typedef enum logic [1:0] {
        LDR_IDLE = 2'b00,
        LDR_SHIFT = 2'b01,
        LDR_END = 2'b11
    } ldr_spi_e;

endpackage

// >>> rtl/ldr_sync2.sv
// Two flip-flop synchroniser for pin inputs.
// Assumes the inputs are asynchronous to clk; reset is asynchronous.
module ldr_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);

    timeunit 1ns;
    timeprecision 1ps;

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    // ----------------------------------------------------------------
    // Synchroniser chain
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stage1_reg <= INIT;
            stage2_reg <= INIT;
        end else begin
            stage1_reg <= async;
            stage2_reg <= stage1_reg;
        end
    end

    assign synced = stage2_reg;

endmodule

// >>> rtl/ldr_result_status.sv
// Loop diagnostic result word with its SPI read path.
// Assumes update strobes come from diagnostic logic on clk; SPI pins are
// asynchronous and sampled at 125 MHz, far faster than the SPI clock.
import ldr_pkg::*;

// Operation
// - Read-only word, only read command answers
// - Bit 19 shows low or high mode
// - Bit 18 high while automatic test runs
// - Bit 16 flags fault before diagnostic start
// - Bit 15 shows driver transistor switched on
// - Bit 14 holds high-side path test pass
// - Bit 13 set when resistance above upper
// - Bit 12 set when resistance below lower
// - Low mode: bits 11:8 echo resistance channel
// - High mode: bits 11:8 give running test
// - Bit 7 flags short between loops
// - Bit 6 flags short to ground
// - Bit 5 flags short to battery
// - Bit 4 gives leakage pin used
// - Bits 3:0 give leakage channel
// - All fields clear on every reset kind
module ldr_result_status #(
    parameter int FRAME_LEN = FRAME_BITS
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic safeStateReset,
    input wire logic wakeStateReset,
    input wire logic spiSck,
    input wire logic spiCsN,
    input wire logic spiMosi,
    output logic spiMisoOut,
    output logic spiMisoOe,
    input wire logic diagLevelHigh,
    input wire logic [3:0] resistanceChannelSelect,
    input wire logic smUpdate,
    input wire logic smTestInProgress,
    input wire logic smPriorFault,
    input wire logic smTransistorOn,
    input wire logic smInterLoopShort,
    input wire logic [3:0] smAutoTestCode,
    input wire logic fetUpdate,
    input wire logic transistor_on_flag,
    input wire logic pathTestDone,
    input wire logic pathTestPass,
    input wire logic resTestDone,
    input wire logic resAboveUpper,
    input wire logic resBelowLower,
    input wire logic leakTestDone,
    input wire logic leakGroundShort,
    input wire logic leakBatteryShort,
    input wire logic leakPinSide,
    input wire logic [3:0] leakChannel,
    output logic [19:0] loopDiagResult
);

    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        ldr_spi_e phase;
        logic sckPrev;
        logic [5:0] bitCount;
        logic [31:0] shiftIn;
        logic [31:0] shiftOut;
        logic misoBit;
        logic misoDrive;
        logic replyPending;
        logic diagLevel;
        logic testInProgress;
        logic priorFault;
        logic transistorOn;
        logic highsidePass;
        logic resAbove;
        logic resBelow;
        logic [3:0] autoCode;
        logic interLoopShort;
        logic groundShort;
        logic batteryShort;
        logic leakPin;
        logic [3:0] leakChan;
    } ldr_state_s;

    localparam ldr_state_s STATE_RESET = '{
        phase: LDR_IDLE,
        sckPrev: 1'b0,
        bitCount: 6'h00,
        shiftIn: 32'h00000000,
        shiftOut: 32'h00000000,
        misoBit: 1'b0,
        misoDrive: 1'b0,
        replyPending: 1'b0,
        diagLevel: RESULT_RESET[DIAG_LEVEL_BIT],
        testInProgress: RESULT_RESET[TEST_IN_PROGRESS_BIT],
        priorFault: RESULT_RESET[PRIOR_FAULT_BIT],
        transistorOn: RESULT_RESET[TRANSISTOR_ON_BIT],
        highsidePass: RESULT_RESET[HIGHSIDE_PASS_BIT],
        resAbove: RESULT_RESET[RES_ABOVE_BIT],
        resBelow: RESULT_RESET[RES_BELOW_BIT],
        autoCode: RESULT_RESET[CODE_HI:CODE_LO],
        interLoopShort: RESULT_RESET[INTER_SHORT_BIT],
        groundShort: RESULT_RESET[GROUND_SHORT_BIT],
        batteryShort: RESULT_RESET[BATTERY_SHORT_BIT],
        leakPin: RESULT_RESET[LEAK_PIN_BIT],
        leakChan: RESULT_RESET[LEAK_CHAN_HI:LEAK_CHAN_LO]
    };

    localparam logic [5:0] FRAME_COUNT = 6'(FRAME_LEN);

    ldr_state_s state_reg;
    ldr_state_s state_next;

    logic sckSync;
    logic csNSync;
    logic mosiSync;
    logic [19:0] resultWord;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    ldr_sync2 #(
        .WIDTH(3),
        .INIT(3'b010)
    ) pinSync (
        .clk(clk),
        .reset(reset),
        .async({spiSck, spiCsN, spiMosi}),
        .synced({sckSync, csNSync, mosiSync})
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Assemble the 20-bit word from its fields
    function automatic logic [19:0] pack_result(input ldr_state_s s);
        logic [19:0] w;
        w = RESULT_RESET;
        w[DIAG_LEVEL_BIT] = s.diagLevel;
        w[TEST_IN_PROGRESS_BIT] = s.testInProgress;
        w[UNUSED_BIT] = 1'b0;
        w[PRIOR_FAULT_BIT] = s.priorFault;
        w[TRANSISTOR_ON_BIT] = s.transistorOn;
        w[HIGHSIDE_PASS_BIT] = s.highsidePass;
        w[RES_ABOVE_BIT] = s.resAbove;
        w[RES_BELOW_BIT] = s.resBelow;
        w[CODE_HI:CODE_LO] = s.autoCode;
        w[INTER_SHORT_BIT] = s.interLoopShort;
        w[GROUND_SHORT_BIT] = s.groundShort;
        w[BATTERY_SHORT_BIT] = s.batteryShort;
        w[LEAK_PIN_BIT] = s.leakPin;
        w[LEAK_CHAN_HI:LEAK_CHAN_LO] = s.leakChan;
        return w;
    endfunction

    // Reply frame for a read issued in the previous frame
    function automatic logic [31:0] reply_frame(input logic pending, input logic [19:0] word);
        logic [31:0] f;
        f = 32'h00000000;
        if (pending) begin
            f = {RESULT_ID, REPLY_PAD, word};
        end
        return f;
    endfunction

    // Only a whole frame carrying the read code arms a reply
    function automatic logic frame_accepted(input logic [31:0] frame, input logic [5:0] count);
        logic ok;
        ok = 1'b0;
        if (count == FRAME_COUNT && frame[CMD_HI:CMD_LO] == RESULT_READ_CODE) begin
            ok = 1'b1;
        end
        return ok;
    endfunction

    // Result fields back to reset; SPI state is left alone
    function automatic ldr_state_s clear_result(input ldr_state_s s);
        ldr_state_s c;
        c = s;
        c.diagLevel = STATE_RESET.diagLevel;
        c.testInProgress = STATE_RESET.testInProgress;
        c.priorFault = STATE_RESET.priorFault;
        c.transistorOn = STATE_RESET.transistorOn;
        c.highsidePass = STATE_RESET.highsidePass;
        c.resAbove = STATE_RESET.resAbove;
        c.resBelow = STATE_RESET.resBelow;
        c.autoCode = STATE_RESET.autoCode;
        c.interLoopShort = STATE_RESET.interLoopShort;
        c.groundShort = STATE_RESET.groundShort;
        c.batteryShort = STATE_RESET.batteryShort;
        c.leakPin = STATE_RESET.leakPin;
        c.leakChan = STATE_RESET.leakChan;
        return c;
    endfunction

    assign resultWord = pack_result(state_reg);

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic sckRise;
        logic sckFall;
        sckRise = 1'b0;
        sckFall = 1'b0;
        state_next = state_reg;
        state_next.sckPrev = sckSync;
        sckRise = sckSync & ~state_reg.sckPrev;
        sckFall = ~sckSync & state_reg.sckPrev;

        // ------------------------------------------------------------
        // SPI frame handling
        // ------------------------------------------------------------
        case (state_reg.phase)
            LDR_IDLE: begin
                state_next.misoDrive = 1'b0;
                state_next.misoBit = 1'b0;
                if (!csNSync) begin
                    // Snapshot taken at frame start keeps the reply coherent
                    state_next.shiftOut = reply_frame(state_reg.replyPending, resultWord);
                    state_next.misoBit = state_next.shiftOut[FRAME_BITS-1];
                    state_next.misoDrive = 1'b1;
                    state_next.bitCount = 6'h00;
                    state_next.phase = LDR_SHIFT;
                end
            end
            LDR_SHIFT: begin
                if (csNSync) begin
                    state_next.phase = LDR_END;
                    state_next.misoDrive = 1'b0;
                end else begin
                    if (sckRise) begin
                        state_next.shiftIn = {state_reg.shiftIn[FRAME_BITS-2:0], mosiSync};
                        // Saturate so an overlong frame cannot wrap to a valid count
                        if (state_reg.bitCount != 6'h3F) begin
                            state_next.bitCount = state_reg.bitCount + 6'h01;
                        end
                    end
                    if (sckFall && state_reg.bitCount != 6'h00) begin
                        state_next.shiftOut = {state_reg.shiftOut[FRAME_BITS-2:0], 1'b0};
                        state_next.misoBit = state_reg.shiftOut[FRAME_BITS-2];
                    end
                end
            end
            LDR_END: begin
                state_next.phase = LDR_IDLE;
                state_next.replyPending = 1'b0;
                state_next.misoBit = 1'b0;
                // Only the read code arms a reply; writes are dropped
                if (frame_accepted(state_reg.shiftIn, state_reg.bitCount)) begin
                    state_next.replyPending = 1'b1;
                end
            end
            default: begin
                state_next.phase = LDR_IDLE;
                state_next.misoDrive = 1'b0;
                state_next.misoBit = 1'b0;
            end
        endcase

        // ------------------------------------------------------------
        // Result word updates
        // ------------------------------------------------------------
        state_next.diagLevel = diagLevelHigh;
        if (!diagLevelHigh) begin
            state_next.autoCode = resistanceChannelSelect;
            state_next.testInProgress = 1'b0;
        end

        // ------------------------------------------------------------
        // State machine loads
        // ------------------------------------------------------------
        if (smUpdate) begin
            state_next.testInProgress = smTestInProgress & diagLevelHigh;
            state_next.priorFault = smPriorFault;
            state_next.transistorOn = smTransistorOn;
            state_next.interLoopShort = smInterLoopShort;
            if (diagLevelHigh) begin
                state_next.autoCode = smAutoTestCode;
            end
        end

        // ------------------------------------------------------------
        // Transistor and path test loads
        // ------------------------------------------------------------
        if (fetUpdate) begin
            state_next.transistorOn = transistor_on_flag;
        end

        if (pathTestDone) begin
            state_next.highsidePass = pathTestPass;
        end

        // ------------------------------------------------------------
        // Resistance test loads
        // ------------------------------------------------------------
        if (resTestDone) begin
            state_next.resAbove = resAboveUpper;
            state_next.resBelow = resBelowLower;
        end

        // ------------------------------------------------------------
        // Leakage test loads
        // ------------------------------------------------------------
        if (leakTestDone) begin
            state_next.groundShort = leakGroundShort;
            state_next.batteryShort = leakBatteryShort;
            state_next.leakPin = leakPinSide;
            state_next.leakChan = leakChannel;
        end

        // ------------------------------------------------------------
        // Wake and safe-state clears override every update
        // ------------------------------------------------------------
        if (safeStateReset || wakeStateReset) begin
            state_next = clear_result(state_next);
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign spiMisoOut = state_reg.misoBit;
    assign spiMisoOe = state_reg.misoDrive;
    assign loopDiagResult = resultWord;

endmodule

// >>> tb/ldr_result_status_monitor.sv
// Concurrent checks on the loop diagnostic result word.
// Assumes binding to ldr_result_status; reset is async, active high.
module ldr_result_status_monitor #(
    parameter int FRAME_LEN = 32
) (
    input wire logic clk, reset, safeStateReset, wakeStateReset,
    input wire logic diagLevelHigh, smUpdate, smTestInProgress, smPriorFault,
    input wire logic smTransistorOn, smInterLoopShort, fetUpdate, transistor_on_flag,
    input wire logic pathTestDone, pathTestPass, resTestDone, resAboveUpper,
    input wire logic resBelowLower, leakTestDone, leakGroundShort, leakBatteryShort,
    input wire logic leakPinSide,
    input wire logic [3:0] resistanceChannelSelect, smAutoTestCode, leakChannel,
    input wire logic [19:0] loopDiagResult
);
    timeunit 1ns;
    timeprecision 1ps;
    logic liveReg;
    logic clr;
    assign clr = safeStateReset | wakeStateReset;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            liveReg <= 1'b0;
        end else begin
            liveReg <= 1'b1;
        end
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (reset);
    // ----------------------------------------------------------------
    // Field checks
    // ----------------------------------------------------------------
    bit_zero_a: assert property (loopDiagResult[17] == 1'b0)
        else $error("unused bit set");
    clear_all_a: assert property (clr |=> loopDiagResult == 20'h00000)
        else $error("result not cleared");
    level_copy_a: assert property (
        liveReg && !clr |=> loopDiagResult[19] == $past(diagLevelHigh))
        else $error("mode bit wrong");
    low_chan_a: assert property (
        liveReg && !clr && !diagLevelHigh |=>
        loopDiagResult[11:8] == $past(resistanceChannelSelect) && !loopDiagResult[18])
        else $error("low mode channel wrong");
    sm_load_a: assert property (
        smUpdate && diagLevelHigh && !clr |=> loopDiagResult[18] == $past(smTestInProgress)
        && loopDiagResult[16] == $past(smPriorFault) && loopDiagResult[7] ==
        $past(smInterLoopShort) && loopDiagResult[11:8] == $past(smAutoTestCode))
        else $error("state machine load wrong");
    fet_load_a: assert property (
        (fetUpdate || smUpdate) && !clr |=> loopDiagResult[15] ==
        ($past(fetUpdate) ? $past(transistor_on_flag) : $past(smTransistorOn)))
        else $error("transistor flag wrong");
    path_load_a: assert property (
        pathTestDone && !clr |=> loopDiagResult[14] == $past(pathTestPass))
        else $error("path flag wrong");
    res_load_a: assert property (
        resTestDone && !clr |=> loopDiagResult[13] == $past(resAboveUpper)
        && loopDiagResult[12] == $past(resBelowLower))
        else $error("range flags wrong");
    leak_load_a: assert property (
        leakTestDone && !clr |=> loopDiagResult[6:0] == {$past(leakGroundShort),
        $past(leakBatteryShort), $past(leakPinSide), $past(leakChannel)})
        else $error("leakage fields wrong");
    hold_fields_a: assert property (
        !clr && !smUpdate && !leakTestDone |=> $stable(loopDiagResult[7:0]))
        else $error("fields changed without cause");
endmodule

// >>> tb/ldr_host_model.sv
// SPI master model standing in for the host controller.
// Assumes mode 0 framing and a MISO line resolved by the bench.
module ldr_host_model (
    output logic spiSck,
    output logic spiCsN,
    output logic spiMosi,
    input wire logic misoLine
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF_NS = 40;
    initial begin
        spiSck = 1'b0;
        spiCsN = 1'b1;
        spiMosi = 1'b0;
    end
    // One frame, MSB first; MOSI inverted once released
    task automatic xfer(input logic [31:0] tx, input int nBits, output logic [31:0] rx);
        rx = '0;
        spiCsN = 1'b0;
        spiMosi = tx[nBits-1];
        #HALF_NS;
        for (int i = nBits - 1; i >= 0; i--) begin
            spiSck = 1'b1;
            rx = {rx[30:0], misoLine};
            #HALF_NS;
            spiSck = 1'b0;
            if (i > 0) spiMosi = tx[i-1];
            #HALF_NS;
        end
        spiCsN = 1'b1;
        spiMosi = ~spiMosi;
        #(3 * HALF_NS);
    endtask
endmodule

// >>> tb/ldr_result_status_tb.sv
// Self-checking bench for the loop diagnostic result word.
// Assumes the host model drives SPI; MISO line has a pull-up.
module ldr_result_status_tb import ldr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset, safeStateReset, wakeStateReset, spiSck, spiCsN, spiMosi;
    logic spiMisoOut, spiMisoOe, misoLine, diagLevelHigh, smUpdate, smTestInProgress;
    logic smPriorFault, smTransistorOn, smInterLoopShort, fetUpdate, transistor_on_flag;
    logic pathTestDone, pathTestPass, resTestDone, resAboveUpper, resBelowLower;
    logic leakTestDone, leakGroundShort, leakBatteryShort, leakPinSide;
    logic [3:0] resistanceChannelSelect, smAutoTestCode, leakChannel;
    logic [19:0] loopDiagResult, expWord;
    logic [31:0] rx;
    int err_count = 0;
    int checked = 0;
    always #4 clk = ~clk;
    assign misoLine = spiMisoOe ? spiMisoOut : 1'b1;
    ldr_result_status #(.FRAME_LEN(32)) dut_u (
        .clk, .reset, .safeStateReset, .wakeStateReset, .spiSck, .spiCsN, .spiMosi,
        .spiMisoOut, .spiMisoOe, .diagLevelHigh, .resistanceChannelSelect, .smUpdate,
        .smTestInProgress, .smPriorFault, .smTransistorOn, .smInterLoopShort,
        .smAutoTestCode, .fetUpdate, .transistor_on_flag, .pathTestDone, .pathTestPass, .resTestDone,
        .resAboveUpper, .resBelowLower, .leakTestDone, .leakGroundShort,
        .leakBatteryShort, .leakPinSide, .leakChannel, .loopDiagResult
    );
    ldr_host_model host_u (.spiSck, .spiCsN, .spiMosi, .misoLine);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [19:0] nextWord(input logic [19:0] w);
        logic [19:0] n;
        n = w;
        n[19] = diagLevelHigh;
        if (!diagLevelHigh) begin
            n[18] = 1'b0;
            n[11:8] = resistanceChannelSelect;
        end
        if (smUpdate) begin
            if (diagLevelHigh) begin
                n[18] = smTestInProgress;
                n[11:8] = smAutoTestCode;
            end
            n[16] = smPriorFault;
            n[15] = smTransistorOn;
            n[7] = smInterLoopShort;
        end
        if (fetUpdate) n[15] = transistor_on_flag;
        if (pathTestDone) n[14] = pathTestPass;
        if (resTestDone) n[13:12] = {resAboveUpper, resBelowLower};
        if (leakTestDone) n[6:0] = {leakGroundShort, leakBatteryShort, leakPinSide, leakChannel};
        if (safeStateReset || wakeStateReset) n = RESULT_RESET;
        return n;
    endfunction
    task automatic step(input string what);
        expWord = nextWord(expWord);
        @(posedge clk);
        #1;
        check(what, {12'h000, loopDiagResult}, {12'h000, expWord});
    endtask
    task automatic quiet();
        {smUpdate, fetUpdate, pathTestDone, resTestDone, leakTestDone} = 5'h00;
        safeStateReset = 1'b0;
        wakeStateReset = 1'b0;
    endtask
    task automatic randDrive(input logic hi);
        logic [31:0] r;
        r = $urandom;
        diagLevelHigh = hi;
        {smTestInProgress, smPriorFault, smTransistorOn, smInterLoopShort} = r[3:0];
        smAutoTestCode = r[7:4];
        {transistor_on_flag, pathTestPass, resAboveUpper, resBelowLower} = r[11:8];
        {leakGroundShort, leakBatteryShort, leakPinSide} = r[14:12];
        leakChannel = r[18:15];
        resistanceChannelSelect = r[22:19];
        {smUpdate, fetUpdate, pathTestDone, resTestDone, leakTestDone} = r[27:23];
        safeStateReset = (r[31:28] == 4'h0);
        wakeStateReset = (r[31:28] == 4'h1);
    endtask
    task automatic clearTo(input logic hi, input logic useWake);
        quiet();
        diagLevelHigh = hi;
        safeStateReset = !useWake;
        wakeStateReset = useWake;
        step("clear");
        quiet();
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'hABDE));
        reset = 1'b1;
        randDrive(1'b0);
        quiet();
        resistanceChannelSelect = 4'h0;
        expWord = RESULT_RESET;
        repeat (20) @(posedge clk);
        #1;
        reset = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check("reset word", {12'h000, loopDiagResult}, 32'h00000000);
        $display("test reset done");
        for (int p = 0; p < 2; p++) begin
            clearTo(p[0], p[0]);
            for (int i = 0; i < 200; i++) begin
                randDrive(p[0]);
                step("random word");
            end
            clearTo(p[0], 1'b0);
            for (int i = 0; i < 16; i++) begin
                smUpdate = p[0];
                smTestInProgress = 1'b1;
                smAutoTestCode = 4'(i);
                resistanceChannelSelect = 4'(i);
                step("code field");
            end
            $display("test mode %0d done", p);
        end
        clearTo(1'b0, 1'b0);
        host_u.xfer({RESULT_ID, 24'hFFFFFF}, 32, rx);
        host_u.xfer(32'h00000000, 32, rx);
        check("reply after write", rx, 32'h00000000);
        step("word after write");
        host_u.xfer({RESULT_READ_CODE, 16'h0000}, 32, rx);
        host_u.xfer(32'h00000000, 32, rx);
        check("read reply", rx, {RESULT_ID, REPLY_PAD, expWord});
        host_u.xfer({1'b0, RESULT_READ_CODE, 15'h0000}, 31, rx);
        host_u.xfer(32'h00000000, 32, rx);
        check("reply after short frame", rx, 32'h00000000);
        $display("test spi done");
        results();
    end
endmodule

bind ldr_result_status ldr_result_status_monitor #(.FRAME_LEN(FRAME_LEN)) mon_u (
    .clk, .reset, .safeStateReset, .wakeStateReset, .diagLevelHigh, .smUpdate,
    .smTestInProgress, .smPriorFault, .smTransistorOn, .smInterLoopShort, .fetUpdate,
    .transistor_on_flag, .pathTestDone, .pathTestPass, .resTestDone, .resAboveUpper, .resBelowLower,
    .leakTestDone, .leakGroundShort, .leakBatteryShort, .leakPinSide,
    .resistanceChannelSelect, .smAutoTestCode, .leakChannel, .loopDiagResult
);
